// ### rtl/cwo_pkg.sv
package cwo_pkg;
    // Number of memory and I/O windows.
    localparam int NUM_MEM_WIN = 5;
    localparam int NUM_IO_WIN = 2;
    // Width of a full memory window offset, A25 down to A12.
    localparam int OFF_W = 14;
    // Width of the upper offset field inside the upper byte.
    localparam int OFF_HI_W = 6;
    // Field positions inside a memory window upper byte.
    localparam int WBLOCK_BIT = 7;
    localparam int SPACE_BIT = 6;
    // Value of every register after reset.
    localparam logic [7:0] REG_RESET = 8'h00;
    // Register indices; the byte address is four times the index.
    localparam logic [5:0] MEM_UP_IDX [NUM_MEM_WIN] =
        '{6'h15, 6'h1d, 6'h25, 6'h2d, 6'h35};
    localparam logic [5:0] MEM_LO_IDX [NUM_MEM_WIN] =
        '{6'h14, 6'h1c, 6'h24, 6'h2c, 6'h34};
    localparam logic [5:0] IO_LO_IDX [NUM_IO_WIN] = '{6'h36, 6'h38};
    // Address bits 13:8 of the base block and of its alias at 2000h.
    localparam logic [5:0] BASE_REGION = 6'h00;
    localparam logic [5:0] ALIAS_REGION = 6'h20;
    // Host window selector codes at or above this are not windows.
    localparam logic [2:0] WIN_LIMIT = 3'h5;
endpackage

// ### rtl/cwo_xlat_if.sv
`timescale 1ns/1ps
`default_nettype none
// Window configuration handed from the register bank to translation.
interface cwo_xlat_if;
    // Full window offsets, A25 down to A12.
    logic [cwo_pkg::OFF_W-1:0] offset [cwo_pkg::NUM_MEM_WIN];
    // Write block flag of each window.
    logic wblock [cwo_pkg::NUM_MEM_WIN];
    // Attribute space flag of each window.
    logic attr [cwo_pkg::NUM_MEM_WIN];
    modport regs (output offset, output wblock, output attr);
    modport xlat (input offset, input wblock, input attr);
endinterface
`default_nettype wire

// ### rtl/cwo_xlat.sv
`timescale 1ns/1ps
`default_nettype none
module cwo_xlat (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    cwo_xlat_if.xlat cfg,
    input wire logic host_valid,
    input wire logic host_write,
    input wire logic [2:0] host_win,
    input wire logic [25:0] host_addr,
    output logic card_valid,
    output logic card_write,
    output logic card_attr,
    output logic card_write_blocked,
    output logic [25:0] card_addr
);
    // Adds offset to the upper host bits; the carry out of A25 is lost.
    function automatic logic [cwo_pkg::OFF_W-1:0] xlat_sum(
        input logic [cwo_pkg::OFF_W-1:0] a,
        input logic [cwo_pkg::OFF_W-1:0] b);
        return a + b;
    endfunction

    // A selector beyond the last window is no window at all.
    logic win_ok;
    logic [2:0] sel;
    logic [cwo_pkg::OFF_W-1:0] sum_w;
    logic block_w;
    logic attr_w;
    assign win_ok = host_win < cwo_pkg::WIN_LIMIT;
    // Steering to window 0 keeps the array index legal.
    assign sel = win_ok ? host_win : 3'h0;
    assign sum_w = xlat_sum(host_addr[25:12], cfg.offset[sel]);
    assign block_w = host_write & cfg.wblock[sel];
    assign attr_w = cfg.attr[sel];

    // Outputs are registered so the card side sees clean values.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            card_valid <= 1'b0;
            card_write <= 1'b0;
            card_attr <= 1'b0;
            card_write_blocked <= 1'b0;
            card_addr <= 26'h0000000;
        end else if (ce) begin
            // A blocked write never reaches the card.
            card_valid <= host_valid & win_ok & ~block_w;
            card_write <= host_write;
            card_attr <= attr_w;
            card_write_blocked <= host_valid & win_ok & block_w;
            card_addr <= {sum_w, host_addr[11:0]};
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_card_addr_sum: assert property (
        ce && host_valid && win_ok |=>
        card_addr == {$past(sum_w), $past(host_addr[11:0])})
        else $error("card address is not host plus offset");
    a_write_block_gate: assert property (
        ce && host_valid && win_ok && host_write && cfg.wblock[sel] |=>
        card_write_blocked && !card_valid)
        else $error("blocked window let a write through");
    a_space_select: assert property (
        ce && host_valid && win_ok |=> card_attr == $past(attr_w))
        else $error("card space does not follow window flag");
    c_blocked_write: cover property (ce && card_write_blocked);
    c_attr_access: cover property (ce && card_valid && card_attr);
endmodule // cwo_xlat
`default_nettype wire

// ### rtl/cwo_regs.sv
`timescale 1ns/1ps
`default_nettype none
module cwo_regs (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic host_valid,
    input wire logic host_write,
    input wire logic [2:0] host_win,
    input wire logic [25:0] host_addr,
    output logic card_valid,
    output logic card_write,
    output logic card_attr,
    output logic card_write_blocked,
    output logic [25:0] card_addr,
    output logic [7:0] io_win0_offset_lower,
    output logic [7:0] io_win1_offset_lower
);
    // True when a decoded index and region match a register index.
    function automatic logic idx_hit(
        input logic [5:0] idx,
        input logic [5:0] ref_idx,
        input logic ok);
        return ok && (idx == ref_idx);
    endfunction

    // A bus request is live while both cycle and strobe are high.
    logic req;
    assign req = wb_cyc_i & wb_stb_i;

    // Acknowledge, registered, one cycle after the request.
    logic ack_r;
    logic ack_nxt;
    assign ack_nxt = req & ~ack_r;
    assign wb_ack_o = ack_r;

    // The register index is the word address inside a block.
    logic [5:0] idx;
    assign idx = wb_adr_i[7:2];

    // The bank answers at the base block and again at 2000h above it.
    logic in_base;
    logic in_alias;
    logic in_map;
    assign in_base = wb_adr_i[13:8] == cwo_pkg::BASE_REGION;
    assign in_alias = wb_adr_i[13:8] == cwo_pkg::ALIAS_REGION;
    // Anything above bit 13 must be zero, which keeps stray high addresses out.
    assign in_map = (wb_adr_i[31:14] == 18'h00000)
                    && (in_base || in_alias);

    // Only the low byte lane carries data; other lanes are ignored.
    // A write lands at the edge where the master samples ack high, so
    // the request is still standing with its data at that moment; a
    // read is captured one edge earlier so its byte is ready by then.
    logic wr_go;
    logic rd_go;
    assign wr_go = req & ack_r & wb_we_i & wb_sel_i[0];
    assign rd_go = ack_nxt & ~wb_we_i;

    // Per-register hit lines.
    logic [cwo_pkg::NUM_MEM_WIN-1:0] hit_up;
    logic [cwo_pkg::NUM_MEM_WIN-1:0] hit_lo;
    logic [cwo_pkg::NUM_IO_WIN-1:0] hit_io;

    // Stored register contents.
    logic [7:0] mem_up_r [cwo_pkg::NUM_MEM_WIN];
    logic [7:0] mem_lo_r [cwo_pkg::NUM_MEM_WIN];
    logic [7:1] io_lo_r [cwo_pkg::NUM_IO_WIN];

    // Configuration handed to the translation logic.
    // One interface carries offsets and flags, so they stay together.
    cwo_xlat_if xif ();

    genvar gw;
    generate
        for (gw = 0; gw < cwo_pkg::NUM_MEM_WIN; gw++) begin : g_mem
            // Upper and lower bytes of one memory window.
            assign hit_up[gw] = idx_hit(idx, cwo_pkg::MEM_UP_IDX[gw],
                                        in_map);
            assign hit_lo[gw] = idx_hit(idx, cwo_pkg::MEM_LO_IDX[gw],
                                        in_map);

            // The upper byte keeps all eight bits as written.
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    mem_up_r[gw] <= cwo_pkg::REG_RESET;
                end else if (ce && wr_go && hit_up[gw]) begin
                    mem_up_r[gw] <= wb_dat_i[7:0];
                end
            end

            // The lower byte holds offset bits A19 to A12.
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    mem_lo_r[gw] <= cwo_pkg::REG_RESET;
                end else if (ce && wr_go && hit_lo[gw]) begin
                    mem_lo_r[gw] <= wb_dat_i[7:0];
                end
            end

            // Upper six bits and lower byte form the 14-bit offset.
            assign xif.offset[gw] = {
                mem_up_r[gw][cwo_pkg::OFF_HI_W-1:0],
                mem_lo_r[gw]};
            assign xif.wblock[gw] =
                mem_up_r[gw][cwo_pkg::WBLOCK_BIT];
            assign xif.attr[gw] =
                mem_up_r[gw][cwo_pkg::SPACE_BIT];
        end

        for (gw = 0; gw < cwo_pkg::NUM_IO_WIN; gw++) begin : g_io
            assign hit_io[gw] = idx_hit(idx, cwo_pkg::IO_LO_IDX[gw],
                                        in_map);

            // Bit 0 has no flop, which keeps I/O offsets even.
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    io_lo_r[gw] <= cwo_pkg::REG_RESET[7:1];
                end else if (ce && wr_go && hit_io[gw]) begin
                    io_lo_r[gw] <= wb_dat_i[7:1];
                end
            end
        end
    endgenerate

    // I/O offsets leave with bit 0 tied low.
    assign io_win0_offset_lower = {io_lo_r[0], 1'b0};
    assign io_win1_offset_lower = {io_lo_r[1], 1'b0};

    // Read selection; unmapped indices and the high lanes read zero.
    logic [7:0] rd_val;
    // The indices never overlap, so at most one hit line fires here.
    always_comb begin
        rd_val = 8'h00;
        for (int w = 0; w < cwo_pkg::NUM_MEM_WIN; w++) begin
            if (hit_up[w]) begin
                rd_val = mem_up_r[w];
            end
            if (hit_lo[w]) begin
                rd_val = mem_lo_r[w];
            end
        end
        for (int w = 0; w < cwo_pkg::NUM_IO_WIN; w++) begin
            if (hit_io[w]) begin
                rd_val = {io_lo_r[w], 1'b0};
            end
        end
    end

    // Acknowledge follows every request, mapped or not, so a stray
    // access can never hang the bus.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ack_r <= 1'b0;
        end else if (ce) begin
            ack_r <= ack_nxt;
        end
    end

    // Read data is captured together with the acknowledge and then
    // held, so it is stable at the edge where the master samples it.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wb_dat_o <= 32'h00000000;
        end else if (ce && rd_go) begin
            wb_dat_o <= {24'h000000, rd_val};
        end
    end

    // Window translation for host accesses to card memory.
    cwo_xlat u_xlat (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .cfg(xif.xlat),
        .host_valid(host_valid),
        .host_write(host_write),
        .host_win(host_win),
        .host_addr(host_addr),
        .card_valid(card_valid),
        .card_write(card_write),
        .card_attr(card_attr),
        .card_write_blocked(card_write_blocked),
        .card_addr(card_addr)
    );

    // All checks below run on the bus clock and rest during reset.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // The acknowledge is a single-cycle pulse.
    a_ack_single_pulse: assert property (
        ce && wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge held more than one cycle");

    // Every fresh request is answered on the following edge.
    a_ack_next_cycle: assert property (
        ce && req && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged in one cycle");

    // Upper bytes decode both at the index and at the alias.
    a_alias_decode: assert property (
        (wb_adr_i[31:2] == {18'h00000, cwo_pkg::ALIAS_REGION, cwo_pkg::MEM_UP_IDX[0]}
         || wb_adr_i[31:2] == {18'h00000, cwo_pkg::BASE_REGION, cwo_pkg::MEM_UP_IDX[0]})
        |-> hit_up[0])
        else $error("window 0 upper byte not decoded");

    // A written upper byte carries offset bits and both flags.
    a_up_byte_write: assert property (
        ce && wr_go && hit_up[2] ##1 1'b1 |->
        xif.offset[2][13:8] == $past(wb_dat_i[5:0])
        && xif.wblock[2] == $past(wb_dat_i[7])
        && xif.attr[2] == $past(wb_dat_i[6]))
        else $error("upper byte fields not stored");

    // A written lower byte becomes offset bits A19 to A12.
    a_lo_byte_write: assert property (
        ce && wr_go && hit_lo[4] |=>
        xif.offset[4][7:0] == $past(wb_dat_i[7:0]))
        else $error("lower byte not stored as A19-A12");

    // I/O lower bytes store bits 7 to 1.
    a_io_bits_write: assert property (
        ce && wr_go && hit_io[1] |=>
        io_win1_offset_lower[7:1] == $past(wb_dat_i[7:1]))
        else $error("I/O lower byte bits 7-1 not stored");

    // Bit 0 of an I/O lower byte reads back zero.
    a_io_bit0_zero: assert property (
        ce && rd_go && (hit_io != 2'h0) |=> wb_dat_o[0] == 1'b0)
        else $error("I/O lower byte bit 0 read as one");

    // Read data returns the addressed upper byte.
    a_up_byte_read: assert property (
        ce && rd_go && hit_up[1] |=> wb_dat_o == {24'h000000,
        $past(mem_up_r[1])})
        else $error("upper byte read data wrong");

    // Writes land only at the edge where the master sees ack high; the
    // edge that takes the request must leave the register untouched.
    a_write_at_ack: assert property (
        ce && req && wb_we_i && !wb_ack_o && hit_up[0]
        |=> $stable(mem_up_r[0]))
        else $error("write landed before the acknowledge");

    // A read never disturbs the byte that it returns.
    a_no_write_on_read: assert property (
        ce && rd_go && hit_up[3] |=> $stable(mem_up_r[3]))
        else $error("read changed an upper byte");

    // The same holds for the lower byte of a memory window.
    a_lo_read_keeps: assert property (
        ce && rd_go && hit_lo[4] |=> $stable(mem_lo_r[4]))
        else $error("read changed a lower byte");

    // Read data returns the addressed lower byte.
    a_lo_byte_read: assert property (
        ce && rd_go && hit_lo[4] |=> wb_dat_o == {24'h000000,
        $past(mem_lo_r[4])})
        else $error("lower byte read data wrong");

    // An I/O lower byte reads back its seven stored bits.
    a_io_read_value: assert property (
        ce && rd_go && hit_io[0] |=> wb_dat_o[7:1] == $past(io_lo_r[0]))
        else $error("I/O lower byte read data wrong");

    // An upper byte read through the alias gives the same byte.
    a_alias_read: assert property (
        ce && rd_go && hit_up[0] && in_alias |=> wb_dat_o == {24'h000000,
        $past(mem_up_r[0])})
        else $error("alias read of window 0 wrong");

    // Places with no register behind them read as zero.
    a_unmapped_read: assert property (
        ce && rd_go && (hit_up == 5'h00) && (hit_lo == 5'h00)
        && (hit_io == 2'h0) |=> wb_dat_o == 32'h00000000)
        else $error("unmapped read returned data");

    // Read data only changes when a new read is taken, so a slow
    // master still finds its byte in place.
    a_dat_hold: assert property (
        !(ce && rd_go) |=> $stable(wb_dat_o))
        else $error("read data changed without a read");

    // An acknowledge always answers a request of the cycle before.
    a_ack_after_req: assert property (
        ce && $past(ce) && wb_ack_o |-> $past(req))
        else $error("acknowledge without a request");

    // Covers for the main scenarios: alias write, I/O read, stray access.
    c_alias_write: cover property (ce && wr_go && in_alias);
    c_io_read: cover property (ce && rd_go && hit_io[0]);
    c_unmapped: cover property (ce && req && !in_map && !wb_ack_o);
endmodule // cwo_regs
`default_nettype wire

// ### verification/cwo_card_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural card on the far side of the window translation.
// It counts forwarded accesses and refused writes, so the bench can
// confirm that nothing extra or missing ever reached the card.
module cwo_card_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic card_valid,
    input wire logic card_write,
    input wire logic card_attr,
    input wire logic card_write_blocked,
    input wire logic [25:0] card_addr,
    output logic [7:0] acc_cnt,
    output logic [7:0] blk_cnt,
    output logic [25:0] last_addr
);
    // Count every forwarded access and every write the window refused.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            acc_cnt <= 8'h00;
            blk_cnt <= 8'h00;
            last_addr <= 26'h0;
        end else begin
            if (card_valid === 1'b1) begin
                acc_cnt <= acc_cnt + 8'h01;
                last_addr <= card_addr;
            end
            // A refused write must never arrive as a real card cycle.
            if (card_write_blocked === 1'b1) begin
                blk_cnt <= blk_cnt + 8'h01;
            end
        end
    end
endmodule // cwo_card_model
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the window offset register bank.
module tb_top;
    logic clk = 1'b0, resetn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [31:0] adr = 32'h0, dat = 32'h0, rdat, q;
    logic [3:0] sel = 4'h0;
    logic ack, hv = 1'b0, hw = 1'b0, cv, cw, ca, cb;
    logic [2:0] hwin = 3'h0;
    logic [25:0] haddr = 26'h0, caddr, laddr;
    logic [7:0] io0, io1, acc, blk;
    int errors = 0, num_checks = 0, cycles = 0;
    // Free running 100 MHz clock.
    always #5 clk = ~clk;
    cwo_regs cwo_regs_inst (.clk(clk), .resetn(resetn), .ce(1'b1), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .host_valid(hv), .host_write(hw),
        .host_win(hwin), .host_addr(haddr), .card_valid(cv), .card_write(cw),
        .card_attr(ca), .card_write_blocked(cb), .card_addr(caddr),
        .io_win0_offset_lower(io0), .io_win1_offset_lower(io1));
    cwo_card_model cwo_card_model_inst (.clk(clk), .resetn(resetn), .card_valid(cv),
        .card_write(cw), .card_attr(ca), .card_write_blocked(cb), .card_addr(caddr),
        .acc_cnt(acc), .blk_cnt(blk), .last_addr(laddr));
    // Compare one value and report a mismatch at once.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Print the counts and the verdict, then stop.
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // A hung handshake must not stall the run forever.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            conclude();
        end
    end
    // One classic Wishbone cycle; data is taken at the edge that sees ack.
    task automatic wb(input logic w, input logic [31:0] a, input logic [7:0] d,
        output logic [31:0] r);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        dat <= {24'h0, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    // Index to byte address, in the base block or in its alias.
    function automatic logic [31:0] ra(input logic [5:0] idx, input logic alias_sel);
        return {18'h0, alias_sel, 5'h0, idx, 2'h0};
    endfunction
    // One host access; the card side answer is read one edge later.
    task automatic host(input logic [2:0] win, input logic [25:0] a, input logic w);
        @(posedge clk);
        hv <= 1'b1;
        hwin <= win;
        haddr <= a;
        hw <= w;
        @(posedge clk);
        hv <= 1'b0;
        @(posedge clk);
    endtask
    // Every memory window upper byte and both I/O lower bytes come out of reset as zero.
    task automatic t_reset;
        for (int i = 0; i < cwo_pkg::NUM_MEM_WIN; i++) begin
            wb(1'b0, ra(cwo_pkg::MEM_UP_IDX[i], 1'b0), 8'h00, q);
            chk(q, 32'h0);
        end
        wb(1'b0, ra(cwo_pkg::IO_LO_IDX[0], 1'b0), 8'h00, q);
        chk(q, 32'h0);
        wb(1'b0, ra(cwo_pkg::IO_LO_IDX[1], 1'b0), 8'h00, q);
        chk(q, 32'h0);
    endtask
    // Each upper byte holds all eight bits and shows at its alias too.
    task automatic t_upper;
        for (int i = 0; i < cwo_pkg::NUM_MEM_WIN; i++) begin
            wb(1'b1, ra(cwo_pkg::MEM_UP_IDX[i], i[0]), 8'hc0 | 8'(i + 8'h31), q);
        end
        for (int i = 0; i < cwo_pkg::NUM_MEM_WIN; i++) begin
            wb(1'b0, ra(cwo_pkg::MEM_UP_IDX[i], ~i[0]), 8'h00, q);
            chk(q, {24'h0, 8'hc0 | 8'(i + 8'h31)});
        end
        wb(1'b1, ra(cwo_pkg::MEM_LO_IDX[4], 1'b1), 8'ha5, q);
        wb(1'b0, ra(cwo_pkg::MEM_LO_IDX[4], 1'b0), 8'h00, q);
        chk(q, 32'ha5);
    endtask
    // The I/O lower bytes keep bit 0 at zero; unmapped places read zero.
    task automatic t_io;
        wb(1'b1, ra(cwo_pkg::IO_LO_IDX[0], 1'b0), 8'hff, q);
        wb(1'b1, ra(cwo_pkg::IO_LO_IDX[1], 1'b0), 8'h55, q);
        wb(1'b0, ra(cwo_pkg::IO_LO_IDX[0], 1'b0), 8'h00, q);
        chk(q, 32'hfe);
        chk({24'h0, io0}, 32'hfe);
        chk({24'h0, io1}, 32'h54);
        wb(1'b1, ra(6'h37, 1'b0), 8'h99, q);
        wb(1'b0, ra(6'h37, 1'b0), 8'h00, q);
        chk(q, 32'h0);
    endtask
    // Offset is added with wrap; bit 6 picks space, bit 7 refuses writes.
    task automatic t_xlat;
        logic [25:0] h;
        logic [13:0] s;
        h = 26'h3f00abc;
        wb(1'b1, ra(cwo_pkg::MEM_UP_IDX[2], 1'b0), 8'h43, q);
        wb(1'b1, ra(cwo_pkg::MEM_LO_IDX[2], 1'b0), 8'h80, q);
        s = h[25:12] + 14'h0380;
        host(3'h2, h, 1'b1);
        chk({31'h0, cv}, 32'h1);
        chk({6'h0, caddr}, {6'h0, s, h[11:0]});
        chk({31'h0, ca}, 32'h1);
        chk({31'h0, cw}, 32'h1);
        wb(1'b1, ra(cwo_pkg::MEM_UP_IDX[2], 1'b1), 8'h83, q);
        host(3'h2, h, 1'b1);
        chk({30'h0, cv, cb}, 32'h1);
        host(3'h2, h, 1'b0);
        chk({30'h0, cv, ca}, 32'h2);
        chk({31'h0, cw}, 32'h0);
        host(3'h5, h, 1'b0);
        chk({30'h0, cv, cb}, 32'h0);
        chk({24'h0, acc}, 32'h2);
        chk({24'h0, blk}, 32'h1);
        chk({6'h0, laddr}, {6'h0, s, h[11:0]});
    endtask
    // Main sequence: reset, then each scenario in turn.
    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_upper();
        t_io();
        t_xlat();
        conclude();
    end
endmodule // tb_top
`default_nettype wire
